// File: rtl/usrt_baud_tick.sv
`timescale 1ns/10ps
`include "usrt_consts.svh"
// one tick per sixteenth of a bit; holds while run is low
module usrt_baud_tick (
    input  wire logic                   mclk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   run_in,
    input  wire logic [`USRT_DIV_W-1:0] divisor_in,
    output logic                        tick_out
);
    logic [`USRT_DIV_W-1:0] cnt_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            tick_out <= 1'b0;
        end else if (cnt_q + 16'd1 >= divisor_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 16'd1;
            tick_out <= 1'b0;
        end
    end
endmodule : usrt_baud_tick

// File: rtl/usrt_consts.svh
`ifndef USRT_CONSTS_SVH
`define USRT_CONSTS_SVH
// sixteen samples per bit
`define USRT_OVS          5'd16
`define USRT_HALF_OVS     5'd8
// stop field encodings
`define USRT_STOP_ONE     2'b00
`define USRT_STOP_HALF    2'b01
`define USRT_STOP_TWO     2'b10
`define USRT_STOP_ONEHALF 2'b11
// break lengths in bit times
`define USRT_BRK_BITS8    4'd10
`define USRT_BRK_BITS9    4'd11
// sample positions, numbered from one
`define USRT_SMP_A        5'd8
`define USRT_SMP_B        5'd9
`define USRT_SMP_C        5'd10
`define USRT_SMP_SC_A     5'd16
`define USRT_SMP_SC_B     5'd17
`define USRT_SMP_SC_C     5'd18
`define USRT_SMP_S3       5'd3
`define USRT_SMP_S5       5'd5
`define USRT_SMP_S7       5'd7
`define USRT_DIV_W        16
`endif

// File: rtl/usrt_pkg.sv
package usrt_pkg;
    typedef enum logic [2:0] {
        TX_OFF, TX_IDLEFRM, TX_WAIT, TX_START, TX_DATA, TX_BREAK, TX_STOP
    } usrt_tx_state_t;
    typedef enum logic [1:0] {
        RX_HUNT, RX_START, RX_DATA, RX_STOP
    } usrt_rx_state_t;
    typedef logic [8:0] usrt_word_t;
endpackage : usrt_pkg

// File: rtl/usrt_rx_sampler.sv
`timescale 1ns/10ps
`include "usrt_consts.svh"
// three-sample majority with noise flag
module usrt_rx_sampler (
    input  wire logic [2:0] samples_in,
    output logic            bit_out,
    output logic            noisy_out
);
    always_comb begin
        bit_out   = (samples_in[0] & samples_in[1]) |
                    (samples_in[0] & samples_in[2]) |
                    (samples_in[1] & samples_in[2]);
        noisy_out = !(samples_in == 3'b000 || samples_in == 3'b111);
    end
endmodule : usrt_rx_sampler

// File: rtl/usrt_tx_rx_framing.sv
`timescale 1ns/10ps
`include "usrt_consts.svh"

module usrt_tx_rx_framing
    import usrt_pkg::*;
(
    input  wire logic                   mclk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   peripheral_enable_in,
    input  wire logic                   transmitter_enable_in,
    input  wire logic                   receiver_enable_in,
    input  wire logic                   word_length_sel_in,
    input  wire logic [1:0]             stop_length_sel_in,
    input  wire logic                   flow_ctrl_en_in,
    input  wire logic                   sync_mode_en_in,
    input  wire logic                   sync_clk_pol_in,
    input  wire logic                   sync_clk_pha_in,
    input  wire logic [`USRT_DIV_W-1:0] baud_div_in,
    input  wire logic                   break_set_in,
    input  wire logic                   break_clr_in,
    input  wire logic                   data_wr_in,
    input  wire usrt_pkg::usrt_word_t   data_wr_val_in,
    input  wire logic                   status_rd_in,
    input  wire logic                   data_rd_in,
    input  wire logic                   tx_empty_irq_en_in,
    input  wire logic                   tx_complete_irq_en_in,
    input  wire logic                   rx_full_irq_en_in,
    input  wire logic                   rx_in,
    input  wire logic                   clear_to_send_in,
    output logic                        tx_out,
    output logic                        request_to_send_out,
    output logic                        sync_clk_out,
    output logic                        break_request_out,
    output logic                        tx_empty_flag_out,
    output logic                        tx_complete_flag_out,
    output logic                        rx_full_flag_out,
    output logic                        noise_flag_out,
    output logic                        framing_error_flag_out,
    output usrt_pkg::usrt_word_t        rx_holding_register_out,
    output logic                        irq_out
);
    import usrt_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // baud ticks
    logic tx_run;
    logic tx_tick;
    logic rx_run;
    logic rx_tick;
    assign tx_run = peripheral_enable_in & transmitter_enable_in;
    assign rx_run = peripheral_enable_in & receiver_enable_in;

    usrt_baud_tick u_tx_baud (
        .mclk_in    (mclk_in),
        .resetn_in  (resetn_in),
        .run_in     (tx_run),
        .divisor_in (baud_div_in),
        .tick_out   (tx_tick)
    );
    usrt_baud_tick u_rx_baud (
        .mclk_in    (mclk_in),
        .resetn_in  (resetn_in),
        .run_in     (rx_run),
        .divisor_in (baud_div_in),
        .tick_out   (rx_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // transmitter
    usrt_tx_state_t tx_st_q;
    usrt_word_t     hold_q;
    logic           hold_full_q;
    usrt_word_t     shf_q;
    logic [3:0]     bit_q;
    logic [4:0]     sub_q;
    logic [5:0]     stop_len;
    logic [3:0]     nbits;
    logic [3:0]     brk_len;
    logic           bit_end;
    logic           data_frame_q;
    logic           tc_armed_q;
    logic           load_now;

    assign nbits    = word_length_sel_in ? 4'd9 : 4'd8;
    assign brk_len  = word_length_sel_in ? `USRT_BRK_BITS9
                                         : `USRT_BRK_BITS8;
    assign bit_end  = tx_tick && sub_q == `USRT_OVS - 5'd1;
    // stop length in sixteenths
    always_comb begin
        case (stop_length_sel_in)
            `USRT_STOP_HALF:    stop_len = 6'd8;
            `USRT_STOP_TWO:     stop_len = 6'd32;
            `USRT_STOP_ONEHALF: stop_len = 6'd24;
            default:            stop_len = 6'd16;
        endcase
    end
    // next frame may start only with cts low under flow control
    assign load_now = tx_st_q == TX_WAIT && tx_tick &&
                      (!flow_ctrl_en_in || !clear_to_send_in);

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_st_q      <= TX_OFF;
            bit_q        <= '0;
            sub_q        <= '0;
            shf_q        <= '0;
            data_frame_q <= 1'b0;
        end else if (!tx_run) begin
            if (!transmitter_enable_in || !peripheral_enable_in)
                tx_st_q <= (tx_st_q == TX_OFF) ? TX_OFF : tx_st_q;
            if (!peripheral_enable_in)
                tx_st_q <= TX_OFF;
        end else if (tx_tick) begin
            case (tx_st_q)
                TX_OFF: begin
                    tx_st_q <= TX_IDLEFRM;
                    sub_q   <= '0;
                    bit_q   <= '0;
                end
                TX_IDLEFRM: begin
                    sub_q <= sub_q + 5'd1;
                    if (bit_end) begin
                        sub_q <= '0;
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == nbits + 4'd1)
                            tx_st_q <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    sub_q <= '0;
                    bit_q <= '0;
                    if (break_request_out) begin
                        tx_st_q      <= TX_BREAK;
                        data_frame_q <= 1'b0;
                    end else if (hold_full_q && load_now) begin
                        tx_st_q      <= TX_START;
                        shf_q        <= hold_q;
                        data_frame_q <= 1'b1;
                    end
                end
                TX_START: begin
                    sub_q <= sub_q + 5'd1;
                    if (bit_end) begin
                        sub_q   <= '0;
                        tx_st_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    sub_q <= sub_q + 5'd1;
                    if (bit_end) begin
                        sub_q <= '0;
                        shf_q <= {1'b0, shf_q[8:1]};
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == nbits - 4'd1) begin
                            bit_q   <= '0;
                            tx_st_q <= TX_STOP;
                        end
                    end
                end
                TX_BREAK: begin
                    sub_q <= sub_q + 5'd1;
                    if (bit_end) begin
                        sub_q <= '0;
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == brk_len - 4'd1)
                            tx_st_q <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if ({1'b0, sub_q} == stop_len - 6'd1 ||
                        sub_q == 5'd31) begin
                        sub_q   <= '0;
                        tx_st_q <= TX_WAIT;
                    end else begin
                        sub_q <= sub_q + 5'd1;
                    end
                end
                default: tx_st_q <= TX_OFF;
            endcase
        end
    end

    // line level: high when idle, idle frame or stop
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in)
            tx_out <= 1'b1;
        else case (tx_st_q)
            TX_START, TX_BREAK: tx_out <= 1'b0;
            TX_DATA:            tx_out <= shf_q[0];
            default:            tx_out <= 1'b1;
        endcase
    end

    // sync clock only over data bits
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in)
            sync_clk_out <= 1'b0;
        else if (sync_mode_en_in && tx_st_q == TX_DATA)
            sync_clk_out <= sync_clk_pol_in ^ sync_clk_pha_in ^
                            (sub_q >= `USRT_HALF_OVS);
        else
            sync_clk_out <= sync_clk_pol_in;
    end

    // break request: set by software, cleared by hardware or software
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in)
            break_request_out <= 1'b0;
        else if (tx_st_q == TX_BREAK && bit_end &&
                 bit_q == brk_len - 4'd1)
            break_request_out <= 1'b0;
        else if (break_set_in)
            break_request_out <= 1'b1;
        else if (break_clr_in && tx_st_q != TX_BREAK)
            break_request_out <= 1'b0;
    end

    // holding register and empty flag
    logic tc_set;
    assign tc_set = tx_st_q == TX_STOP && tx_tick && data_frame_q &&
                    ({1'b0, sub_q} == stop_len - 6'd1) &&
                    !hold_full_q;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hold_q      <= '0;
            hold_full_q <= 1'b0;
        end else if (data_wr_in) begin
            hold_q      <= data_wr_val_in;
            hold_full_q <= 1'b1;
        end else if (tx_st_q == TX_WAIT && tx_tick && hold_full_q &&
                     load_now && !break_request_out) begin
            hold_full_q <= 1'b0;
        end
    end
    assign tx_empty_flag_out = !hold_full_q;

    // complete flag: status read arms, data write clears
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_complete_flag_out <= 1'b0;
            tc_armed_q           <= 1'b0;
        end else begin
            if (tc_set)
                tx_complete_flag_out <= 1'b1;
            else if (data_wr_in && tc_armed_q)
                tx_complete_flag_out <= 1'b0;
            if (status_rd_in && tx_complete_flag_out)
                tc_armed_q <= 1'b1;
            else if (data_wr_in)
                tc_armed_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receiver
    usrt_rx_state_t rx_st_q;
    logic [4:0]     rsub_q;
    logic [3:0]     rbit_q;
    logic [2:0]     smp_q;
    logic [2:0]     grp_a_q;
    usrt_word_t     rshf_q;
    logic           rnoise_q;
    logic           maj;
    logic           noisy;
    logic [4:0]     rpos;
    logic [4:0]     sc;

    usrt_rx_sampler u_samp (
        .samples_in (smp_q),
        .bit_out    (maj),
        .noisy_out  (noisy)
    );
    assign rpos = rsub_q + 5'd1;
    assign request_to_send_out = !(flow_ctrl_en_in && rx_run &&
                                   !rx_full_flag_out);
    always_comb begin
        sc = `USRT_SMP_C;
        if (rx_st_q == RX_STOP &&
            stop_length_sel_in == `USRT_STOP_ONEHALF) begin
            sc = `USRT_SMP_SC_C;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_st_q  <= RX_HUNT;
            rsub_q   <= '0;
            rbit_q   <= '0;
            smp_q    <= 3'b111;
            grp_a_q  <= 3'b111;
            rshf_q   <= '0;
            rnoise_q <= 1'b0;
        end else if (!rx_run) begin
            rx_st_q <= RX_HUNT;
            smp_q   <= 3'b111;
        end else if (rx_tick) begin
            smp_q <= {rx_in, smp_q[2:1]};
            case (rx_st_q)
                RX_HUNT: begin
                    rsub_q <= '0;
                    if (smp_q == 3'b111 && !rx_in)
                        rx_st_q <= RX_START;
                end
                RX_START: begin
                    rsub_q <= rsub_q + 5'd1;
                    if (rpos == `USRT_SMP_S3) grp_a_q[0] <= rx_in;
                    if (rpos == `USRT_SMP_S5) grp_a_q[1] <= rx_in;
                    if (rpos == `USRT_SMP_S7) grp_a_q[2] <= rx_in;
                    if (rpos == `USRT_SMP_C + 5'd1) begin
                        // majority zero in both groups accepts
                        if (!maj && !(grp_a_q[0] & grp_a_q[1] |
                            grp_a_q[0] & grp_a_q[2] |
                            grp_a_q[1] & grp_a_q[2])) begin
                            rnoise_q <= noisy || grp_a_q != 3'b000;
                        end else begin
                            rx_st_q <= RX_HUNT;
                        end
                    end
                    if (rpos == `USRT_OVS) begin
                        rsub_q <= '0;
                        rbit_q <= '0;
                        rx_st_q <= RX_DATA;
                    end
                end
                RX_DATA: begin
                    rsub_q <= rsub_q + 5'd1;
                    if (rpos == `USRT_SMP_C + 5'd1) begin
                        rshf_q <= word_length_sel_in ?
                                  {maj, rshf_q[8:1]} :
                                  {1'b0, maj, rshf_q[7:1]};
                        if (noisy) rnoise_q <= 1'b1;
                    end
                    if (rpos == `USRT_OVS) begin
                        rsub_q <= '0;
                        rbit_q <= rbit_q + 4'd1;
                        if (rbit_q == nbits - 4'd1)
                            rx_st_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    rsub_q <= rsub_q + 5'd1;
                    if (stop_length_sel_in == `USRT_STOP_HALF ||
                        rpos == sc + 5'd1 ||
                        rpos == 5'd31)
                        rx_st_q <= RX_HUNT;
                end
                default: rx_st_q <= RX_HUNT;
            endcase
        end
    end

    // word handoff to holding register with flags
    logic rx_done;
    logic rx_ferr;
    assign rx_done = rx_run && rx_tick && rx_st_q == RX_STOP &&
                     (stop_length_sel_in == `USRT_STOP_HALF ||
                      rpos == sc + 5'd1);
    // half stop bit leaves framing unchecked
    assign rx_ferr = stop_length_sel_in != `USRT_STOP_HALF && !maj;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_holding_register_out <= '0;
            rx_full_flag_out        <= 1'b0;
            noise_flag_out          <= 1'b0;
            framing_error_flag_out  <= 1'b0;
        end else if (rx_done) begin
            rx_holding_register_out <= rshf_q;
            rx_full_flag_out        <= 1'b1;
            noise_flag_out          <= rnoise_q;
            framing_error_flag_out  <= rx_ferr;
        end else if (data_rd_in) begin
            rx_full_flag_out        <= 1'b0;
            noise_flag_out          <= 1'b0;
            framing_error_flag_out  <= 1'b0;
        end
    end

    assign irq_out = (tx_empty_irq_en_in && tx_empty_flag_out) ||
                     (tx_complete_irq_en_in && tx_complete_flag_out) ||
                     (rx_full_irq_en_in && rx_full_flag_out);
endmodule : usrt_tx_rx_framing

// File: tb/tb.sv
`timescale 1ns/10ps
`include "usrt_consts.svh"
module tb;
    import usrt_pkg::*;
    logic mclk_in, resetn_in, peripheral_enable_in, transmitter_enable_in;
    logic receiver_enable_in, word_length_sel_in, flow_ctrl_en_in;
    logic sync_mode_en_in, sync_clk_pol_in, sync_clk_pha_in, break_set_in;
    logic break_clr_in, data_wr_in, status_rd_in, data_rd_in, rx_in;
    logic tx_empty_irq_en_in, tx_complete_irq_en_in, rx_full_irq_en_in;
    logic clear_to_send_in, tx_out, request_to_send_out, sync_clk_out;
    logic break_request_out, tx_empty_flag_out, tx_complete_flag_out;
    logic rx_full_flag_out, noise_flag_out, framing_error_flag_out, irq_out;
    logic [1:0] stop_length_sel_in;
    logic [`USRT_DIV_W-1:0] baud_div_in;
    usrt_word_t data_wr_val_in, rx_holding_register_out, far_word, w, v;
    logic far_send, far_ready;
    logic [3:0] far_glitch;
    int err_count, n_compared, s, d, len;
    int stop_cyc[4] = '{16, 8, 32, 24};
    usrt_tx_rx_framing u_dut (.*);
    usrt_far_end u_far (.mclk_in(mclk_in), .send_in(far_send),
        .word_in(far_word), .nine_in(word_length_sel_in),
        .glitch_in(far_glitch), .ready_in(far_ready),
        .rx_line_out(rx_in), .clear_to_send_out(clear_to_send_in));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic tally_and_finish;
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input usrt_word_t got, input usrt_word_t exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask : chk
    task automatic near(input int got, input int exp);
        n_compared++;
        if (got < exp - 3 || got > exp + 3) begin
            err_count++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask : near
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : tick
    task automatic hang;
        err_count++;
        tally_and_finish;
    endtask : hang
    task automatic wr(input usrt_word_t val, input logic rd);
        status_rd_in = rd;
        tick(rd);
        status_rd_in = 1'b0;
        data_wr_in = 1'b1;
        data_wr_val_in = val;
        tick(1);
        data_wr_in = 1'b0;
        tick(1);
    endtask : wr
    task automatic tx_frame(input int nb, input bit wc);
        for (d = 0; tx_out !== 1'b0; d++) begin
            if (d > 4000) hang;
            tick(1);
        end
        w = '0;
        tick(8);
        chk(sync_clk_out, 1'b0);
        for (int i = 0; i < nb; i++) begin
            tick(16);
            w[i] = tx_out;
            chk(sync_clk_out, 1'b1);
        end
        tick(16);
        chk(tx_out, 1'b1);
        chk(sync_clk_out, 1'b0);
        for (len = 24 + 16 * nb; wc && tx_complete_flag_out !== 1'b1; len++)
            if (len < 600) tick(1); else hang;
    endtask : tx_frame
    task automatic rx_word(input usrt_word_t val, input logic [3:0] g,
                           input logic nz);
        far_word = val;
        far_glitch = g;
        far_send = 1'b1;
        tick(1);
        far_send = 1'b0;
        for (d = 0; rx_full_flag_out !== 1'b1; d++)
            if (d < 400) tick(1); else hang;
        chk(rx_holding_register_out, val);
        chk(noise_flag_out, nz);
        chk(framing_error_flag_out, 1'b0);
        chk(irq_out, 1'b1);
        data_rd_in = 1'b1;
        tick(1);
        data_rd_in = 1'b0;
        tick(40);
        chk(rx_full_flag_out, 1'b0);
    endtask : rx_word
    initial begin
        {peripheral_enable_in, transmitter_enable_in, receiver_enable_in,
         word_length_sel_in, flow_ctrl_en_in, sync_mode_en_in,
         sync_clk_pol_in, sync_clk_pha_in, break_set_in, break_clr_in,
         data_wr_in, status_rd_in, data_rd_in, tx_empty_irq_en_in,
         tx_complete_irq_en_in, far_send, resetn_in} = '0;
        {stop_length_sel_in, data_wr_val_in, far_word, w, v} = '0;
        baud_div_in = 16'h1;
        far_glitch = 4'hf;
        far_ready = 1'b1;
        sync_mode_en_in = 1'b1;
        rx_full_irq_en_in = 1'b1;
        err_count = 0;
        n_compared = 0;
        tick(5);
        resetn_in = 1'b1;
        tick(1);
        chk(tx_out, 1'b1);
        chk(tx_empty_flag_out, 1'b1);
        chk(request_to_send_out, 1'b1);
        {peripheral_enable_in, transmitter_enable_in} = 2'h3;
        receiver_enable_in = 1'b1;
        tick(1);
        for (s = 0; s < 4; s++) begin
            stop_length_sel_in = s[1:0];
            word_length_sel_in = s[0];
            v = 9'h1c3 ^ 9'(s * 90);
            wr(v, s > 0);
            if (s > 0) chk(tx_complete_flag_out, 1'b0);
            tx_frame(8 + s % 2, 1'b1);
            if (s == 0) near(d, 160);
            chk(w, v & (s[0] ? 9'h1ff : 9'h0ff));
            near(len, 16 * (9 + s % 2) + stop_cyc[s]);
            chk(tx_complete_flag_out, 1'b1);
        end
        {word_length_sel_in, stop_length_sel_in} = 3'h0;
        wr(9'h03c, 1'b0);
        chk(tx_complete_flag_out, 1'b1);
        wr(9'h0e1, 1'b0);
        chk(tx_empty_flag_out, 1'b0);
        tx_frame(8, 1'b0);
        chk(w, 9'h03c);
        tx_frame(8, 1'b1);
        chk(w, 9'h0e1);
        flow_ctrl_en_in = 1'b1;
        far_ready = 1'b0;
        wr(9'h096, 1'b0);
        tick(100);
        chk(tx_out, 1'b1);
        chk(request_to_send_out, 1'b0);
        far_ready = 1'b1;
        tx_frame(8, 1'b1);
        chk(w, 9'h096);
        flow_ctrl_en_in = 1'b0;
        break_set_in = 1'b1;
        tick(1);
        break_set_in = 1'b0;
        for (d = 0; tx_out !== 1'b0; d++)
            if (d < 400) tick(1); else hang;
        tick(24);
        chk(tx_out, 1'b0);
        for (len = 24; tx_out === 1'b0; len++)
            if (len < 400) tick(1); else hang;
        near(len, 160);
        tick(8);
        chk(break_request_out, 1'b0);
        chk(tx_out, 1'b1);
        wr(9'h055, 1'b1);
        tick(20);
        break_set_in = 1'b1;
        tick(1);
        {break_set_in, break_clr_in} = 2'h1;
        tick(1);
        break_clr_in = 1'b0;
        tick(200);
        len = 0;
        for (s = 0; s < 200; s++) begin
            if (tx_out !== 1'b1) len++;
            tick(1);
        end
        chk(9'(len), 9'h0);
        rx_word(9'h03c, 4'hf, 1'b0);
        word_length_sel_in = 1'b1;
        rx_word(9'h15a, 4'h3, 1'b1);
        wr(9'h1f0, 1'b1);
        tick(40);
        transmitter_enable_in = 1'b0;
        tick(1);
        v = 9'(tx_out);
        tick(100);
        chk(tx_out, v);
        tally_and_finish;
    end
endmodule : tb

// File: tb/usrt_far_end.sv
`timescale 1ns/10ps
// serial device on the far side; one bit is 16 clocks (divisor of one)
module usrt_far_end (
    input  wire logic       mclk_in,
    input  wire logic       send_in,
    input  wire logic [8:0] word_in,
    input  wire logic       nine_in,
    input  wire logic [3:0] glitch_in,
    input  wire logic       ready_in,
    output logic            rx_line_out,
    output logic            clear_to_send_out
);
    logic [10:0] frm;
    // pulled low while this side accepts the next frame
    assign clear_to_send_out = ~ready_in;
    initial rx_line_out = 1'b1;
    // start low, data lsb first, stop high; one sample may be flipped
    always @(posedge mclk_in) begin
        if (send_in) begin
            frm = nine_in ? {1'b1, word_in, 1'b0}
                          : {2'b11, word_in[7:0], 1'b0};
            for (int n = 0; n < 11; n++) begin
                for (int k = 0; k < 16; k++) begin
                    rx_line_out <= frm[n] ^ (n == glitch_in && k == 8);
                    @(posedge mclk_in);
                end
            end
        end
    end
endmodule : usrt_far_end

// File: tb/usrt_tx_rx_framing_properties.sv
`timescale 1ns/10ps
module usrt_framing_chk (
    input wire logic        mclk_in,
    input wire logic        resetn_in,
    input wire logic        transmitter_enable_in,
    input wire logic        receiver_enable_in,
    input wire logic        flow_ctrl_en_in,
    input wire logic [15:0] baud_div_in,
    input wire logic        data_wr_in,
    input wire logic        status_rd_in,
    input wire logic        clear_to_send_in,
    input wire logic        tx_out,
    input wire logic        request_to_send_out,
    input wire logic        tx_empty_flag_out,
    input wire logic        tx_complete_flag_out,
    input wire logic        rx_full_flag_out
);
    logic [31:0] low_run_q;
    // length of the current low stretch on the line
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_run_q <= 32'h0;
        end else begin
            low_run_q <= tx_out ? 32'h0 : low_run_q + 32'h1;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_read_then_write;
        status_rd_in && tx_complete_flag_out ##1 data_wr_in;
    endsequence
    low_run_bound_a: assert property ($rose(tx_out) |->
        low_run_q <= 32'd176 * baud_div_in + 32'h2)
        else $error("line held low too long");
    write_clears_empty_a: assert property (data_wr_in |=>
        !tx_empty_flag_out) else $error("empty flag not cleared");
    complete_clear_a: assert property (s_read_then_write |=>
        !tx_complete_flag_out) else $error("complete flag not cleared");
    complete_needs_empty_a: assert property ($rose(tx_complete_flag_out)
        |-> $past(tx_empty_flag_out) && tx_out)
        else $error("early complete");
    cts_gate_a: assert property ($fell(tx_out) && flow_ctrl_en_in &&
        $past(tx_complete_flag_out) |-> !$past(clear_to_send_in, 2))
        else $error("frame started without clear to send");
    rts_ready_a: assert property (!request_to_send_out |->
        flow_ctrl_en_in && !rx_full_flag_out)
        else $error("ready shown without flow control");
    rx_full_rise_a: assert property ($rose(rx_full_flag_out) |->
        receiver_enable_in) else $error("word taken while disabled");
    frozen_line_a: assert property (!transmitter_enable_in &&
        !$past(transmitter_enable_in) &&
        !$past(transmitter_enable_in, 2) |-> $stable(tx_out))
        else $error("line moved while disabled");
endmodule : usrt_framing_chk
bind usrt_tx_rx_framing usrt_framing_chk u_chk (.*);
